// ### dv/pvc_mac_model.sv
// mac side model driving the mii transmit lines
// assumes clk and srst shared with the vendor control block
`timescale 1ns/1ps
module pvc_mac_model
   import pvc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire logic [7:0] nibbles,
   output logic tx_en,
   output logic [3:0] txd,
   output logic busy
);
   import pvc_pkg::*;

   logic [7:0] left;
   logic [3:0] pat;

   // ****************************************
   // frame sender
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         left <= 8'h00;
         tx_en <= 1'b0;
         txd <= 4'hA;
         pat <= 4'h3;
      end else begin
         if (start && left == 8'h00) begin
            left <= nibbles;
         end else if (left != 8'h00) begin
            left <= left - 8'h01;
         end
         tx_en <= (left != 8'h00);
         if (left != 8'h00) begin
            txd <= pat;
            pat <= pat + 4'h5;
         end else begin
            // idle nibble changes so a stale copy never looks right
            txd <= ~txd;
         end
      end
   end

   assign busy = (left != 8'h00) || tx_en;
endmodule

// ### dv/tb_top.sv
// self-checking bench for the vendor control register block
// assumes the mac model drives tx_en and txd, bench drives the rest
`timescale 1ns/1ps
module tb_top;
   import pvc_pkg::*;
   logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, sh = 16'h0000;
   logic mode_10bt = 1'b0, aneg_active = 1'b0, duplex_request = 1'b0;
   logic rx_activity = 1'b0, phy_rx_dv = 1'b0, tx_clk_gen = 1'b0;
   logic [3:0] phy_rxd = 4'h0, txd, rxd, pd;
   logic [1:0] tx_line_drive = 2'h0, tx_line_pair;
   logic rx_line_in = 1'b1, nlp_pulse = 1'b0, nlp_inverted = 1'b0;
   logic flp_done = 1'b0, flp_inverted = 1'b0, mac_start = 1'b0;
   logic [7:0] irq_status = 8'h00, irq_enable = 8'h00, mac_len = 8'h00;
   logic full_duplex, crs, col, tx_en, rx_dv, tx_line_pair_oe, tx_clk_out;
   logic tx_clk_oe, rx_line_data, irq_out, busy, pe, lvl, pend, pend_prev;
   logic [15:0] exp_q[$];
   logic [15:0] d;
   int err_count = 0, samples_checked = 0, n;

   always #25 clk = ~clk;

   pvc_vendor_control i_pvc_vendor_control (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode_10bt(mode_10bt),
      .aneg_active(aneg_active), .duplex_request(duplex_request),
      .full_duplex(full_duplex), .rx_activity(rx_activity), .crs(crs),
      .col(col), .tx_en(tx_en), .txd(txd), .phy_rx_dv(phy_rx_dv),
      .phy_rxd(phy_rxd), .rx_dv(rx_dv), .rxd(rxd),
      .tx_line_drive(tx_line_drive), .tx_line_pair(tx_line_pair),
      .tx_line_pair_oe(tx_line_pair_oe), .tx_clk_gen(tx_clk_gen),
      .tx_clk_out(tx_clk_out), .tx_clk_oe(tx_clk_oe),
      .rx_line_in(rx_line_in), .rx_line_data(rx_line_data),
      .nlp_pulse(nlp_pulse), .nlp_inverted(nlp_inverted),
      .flp_done(flp_done), .flp_inverted(flp_inverted),
      .irq_status(irq_status), .irq_enable(irq_enable), .irq_out(irq_out));

   pvc_mac_model i_pvc_mac_model (.clk(clk), .srst(srst), .start(mac_start),
      .nibbles(mac_len), .tx_en(tx_en), .txd(txd), .busy(busy));

   // ****************************************
   // shared tasks
   // ****************************************
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task end_sim;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task tick(input int k);
      repeat (k) @(posedge clk);
      #5;
   endtask

   task wr(input logic [4:0] a, input logic [15:0] v);
      logic [15:0] wm;
      wm = 16'hDC2C | (sh[BIT_POLARITY_AUTO_DISABLE_DIS] ? 16'h0010 : 16'h0000);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      if (a == VCR_ADDR) begin
         sh = (sh & ~wm) | (v & wm);
      end
   endtask

   task rd(input logic [4:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      exp_q.push_back(a == VCR_ADDR ? ((sh & ~FIXED_MASK) | FIXED_ONES)
                                    : 16'h0000);
      tick(1);
      reg_rd = 1'b0;
      tick(2);
   endtask

   task setc(input logic [15:0] v);
      wr(VCR_ADDR, v & 16'hFFF3);
      tick(1);
   endtask

   task do_reset;
      srst = 1'b1;
      tick(8);
      srst = 1'b0;
      sh = 16'h0000;
   endtask

   task nlp(input logic inv);
      nlp_pulse = 1'b1;
      nlp_inverted = inv;
      tick(1);
      nlp_pulse = 1'b0;
      nlp_inverted = 1'b0;
      tick(1);
   endtask

   task frame(input logic [7:0] k);
      mac_start = 1'b1;
      mac_len = k;
      tick(1);
      mac_start = 1'b0;
   endtask

   task wait_idle;
      int k;
      k = 0;
      while (busy && k < 100) begin
         tick(1);
         k++;
      end
      if (busy) begin
         $display("wrong value mac_busy expected 0 seen 1");
         err_count++;
         end_sim();
      end
   endtask

   // ****************************************
   // read data monitor
   // ****************************************
   initial begin
      pend_prev = 1'b0;
      forever begin
         @(posedge clk);
         pend = reg_rd & ~srst;
         #2;
         if (pend_prev) begin
            if (exp_q.size() == 0) begin
               chk("unexpected_read", 16'h0000, 16'h0001);
            end else begin
               chk("reg_rdata", exp_q.pop_front(), reg_rdata);
            end
         end
         pend_prev = pend;
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'hEE9B));
      do_reset();
      rd(VCR_ADDR);
      chk("tx_line_pair_oe", 16'h0001, {15'h0, tx_line_pair_oe});
      tx_line_drive = 2'h2;
      tx_clk_gen = 1'b1;
      tick(2);
      chk("tx_line_pair", 16'h0002, {14'h0, tx_line_pair});
      chk("tx_clk_out", 16'h0001, {15'h0, tx_clk_out});
      // register map with unmapped place
      for (int i = 0; i < 6; i++) begin
         setc(16'($urandom));
         rd(VCR_ADDR);
         wr(5'h11, 16'($urandom));
         rd(5'h11);
      end
      // interrupt level and masking
      for (int i = 0; i < 8; i++) begin
         lvl = (i >= 4);
         setc({1'b0, lvl, 14'h0000});
         irq_status = 8'($urandom);
         irq_enable = i[0] ? 8'($urandom) : 8'h00;
         tick(2);
         chk("irq_out", {15'h0, (|(irq_status & irq_enable)) ? lvl : ~lvl},
             {15'h0, irq_out});
      end
      // transmitter release
      setc(16'h1000);
      rx_line_in = 1'b0;
      tick(2);
      chk("tx_oe", 16'h0000, {14'h0, tx_line_pair_oe, tx_clk_oe});
      chk("rx_line_data", 16'h0000, {15'h0, rx_line_data});
      // repeater and heartbeat cases
      for (int c = 0; c < 4; c++) begin
         d = 16'h0000;
         d[BIT_REPEATER] = (c == 2);
         d[BIT_HB_INHIBIT] = (c == 1);
         mode_10bt = (c != 3);
         duplex_request = 1'b1;
         setc(d);
         tick(2);
         chk("full_duplex", {15'h0, c != 2}, {15'h0, full_duplex});
         duplex_request = 1'b0;
         tick(2);
         frame(8'h06);
         tick(2);
         chk("crs", {15'h0, c != 2}, {15'h0, crs});
         n = 0;
         for (int k = 0; k < 60; k++) begin
            n += int'(col);
            tick(1);
         end
         chk("sqe_cycles", 16'((c == 0) ? SQE_CYCLES : 0), 16'(n));
         wait_idle();
         rx_activity = 1'b1;
         tick(2);
         chk("crs_rx", 16'h0001, {15'h0, crs});
         rx_activity = 1'b0;
         tick(2);
      end
      // ten megabit loopback
      mode_10bt = 1'b1;
      setc(16'h0400);
      frame(8'h05);
      for (int k = 0; k < 9; k++) begin
         pe = tx_en;
         pd = txd;
         tick(1);
         chk("loop_rxd", {11'h0, pe, pd}, {11'h0, rx_dv, rxd});
      end
      wait_idle();
      // loopback bit left set, but not in 10 Mb/s mode
      mode_10bt = 1'b0;
      phy_rx_dv = 1'b1;
      phy_rxd = 4'($urandom);
      tick(2);
      chk("phy_rxd", {11'h0, 1'b1, phy_rxd}, {11'h0, rx_dv, rxd});
      phy_rx_dv = 1'b0;
      tick(1);
      // polarity by normal link pulses
      do_reset();
      aneg_active = 1'b1;
      rx_line_in = 1'b1;
      repeat (7) nlp(1'b1);
      tick(4);
      chk("rx_line_data", 16'h0001, {15'h0, rx_line_data});
      nlp(1'b1);
      tick(4);
      chk("rx_line_data", 16'h0000, {15'h0, rx_line_data});
      sh[BIT_RX_FLIP] = 1'b1;
      rd(VCR_ADDR);
      // polarity by one fast burst
      do_reset();
      mode_10bt = 1'b0;
      flp_done = 1'b1;
      flp_inverted = 1'b1;
      tick(1);
      flp_done = 1'b0;
      flp_inverted = 1'b0;
      tick(4);
      chk("rx_line_data", 16'h0000, {15'h0, rx_line_data});
      // correction off, manual flip
      do_reset();
      setc(16'h0020);
      repeat (8) nlp(1'b1);
      tick(4);
      chk("rx_line_data", 16'h0001, {15'h0, rx_line_data});
      setc(16'h0030);
      tick(2);
      chk("rx_line_data", 16'h0000, {15'h0, rx_line_data});
      rd(VCR_ADDR);
      tick(4);
      chk("pending_reads", 16'h0000, 16'(exp_q.size()));
      end_sim();
   end
endmodule

// ### hw/pvc_pkg.sv
// package of constants for the vendor control register block
// assumes a single 20 MHz clock and a synchronous active-high reset
package pvc_pkg;

   // ****************************************
   // register address and field positions
   // ****************************************
   localparam logic [4:0] VCR_ADDR = 5'h10;
   localparam int BIT_REPEATER = 15;
   localparam int BIT_IRQ_LEVEL = 14;
   localparam int BIT_RSV13 = 13;
   localparam int BIT_TX_HIZ = 12;
   localparam int BIT_HB_INHIBIT = 11;
   localparam int BIT_LOOPBACK = 10;
   localparam int BIT_POLARITY_AUTO_DISABLE_DIS = 5;
   localparam int BIT_RX_FLIP = 4;
   localparam int RSV_RW_MSB = 3;
   localparam int RSV_RW_LSB = 2;

   // ****************************************
   // fixed read values and reset values
   // ****************************************
   localparam logic [15:0] FIXED_ONES = 16'h0140;
   localparam logic [15:0] FIXED_MASK = 16'h23C3;
   localparam logic RST_REPEATER = 1'b0;
   localparam logic RST_IRQ_LEVEL = 1'b0;
   localparam logic RST_TX_HIZ = 1'b0;
   localparam logic RST_HB_INHIBIT = 1'b0;
   localparam logic RST_LOOPBACK = 1'b0;
   localparam logic RST_POLARITY_AUTO_DISABLE_DIS = 1'b0;
   localparam logic RST_RX_FLIP = 1'b0;
   localparam logic [1:0] RST_RSV_RW = 2'h0;
   localparam logic [15:0] RST_RDATA = 16'h0000;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS = 50;
   localparam int SQE_NS = 1000;
   localparam int SQE_CYCLES = (SQE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [4:0] SQE_LAST = 5'(SQE_CYCLES - 1);
   localparam int NLP_REVERSE_COUNT = 8;
   localparam logic [3:0] NLP_LAST = 4'(NLP_REVERSE_COUNT - 1);

   typedef enum logic {PVC_SQE_IDLE, PVC_SQE_PULSE} pvc_sqe_e;

endpackage

// ### hw/pvc_polarity_detect.sv
// link pulse polarity detector
// assumes pulse qualifiers are synchronous one-cycle strobes
`timescale 1ns/1ps
module pvc_polarity_detect
   import pvc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic enable,
   input wire logic nlp_pulse,
   input wire logic nlp_inverted,
   input wire logic flp_done,
   input wire logic flp_inverted,
   output logic reversed
);
   import pvc_pkg::*;

   logic [3:0] inv_count;

   // ****************************************
   // inverted pulse counting
   // ****************************************
   // eight nlps or one flp
   always_ff @(posedge clk) begin
      if (srst || !enable) begin
         inv_count <= 4'h0;
         reversed <= 1'b0;
      end else begin
         reversed <= 1'b0;
         if (flp_done && flp_inverted) begin
            reversed <= 1'b1;
            inv_count <= 4'h0;
         end else if (nlp_pulse) begin
            if (!nlp_inverted) begin
               inv_count <= 4'h0;
            end else if (inv_count == NLP_LAST) begin
               reversed <= 1'b1;
               inv_count <= 4'h0;
            end else begin
               inv_count <= inv_count + 4'h1;
            end
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_nlp_eighth;
      enable && nlp_pulse && nlp_inverted && !flp_done &&
         inv_count == NLP_LAST |=> reversed;
   endproperty
   a_nlp_eighth: assert property (p_nlp_eighth)
      else $error("eighth inverted nlp not declared");

   property p_nlp_early;
      enable && nlp_pulse && nlp_inverted && !flp_done &&
         inv_count < NLP_LAST |=> !reversed;
   endproperty
   a_nlp_early: assert property (p_nlp_early)
      else $error("reversal declared before eighth nlp");

   c_flp_reverse: cover property (enable && flp_done && flp_inverted);
endmodule

// ### hw/pvc_vendor_control.sv
// vendor control register with the mode logic that it steers
// assumes mii, link pulse and management strobes synchronous to clk
`timescale 1ns/1ps
module pvc_vendor_control
   import pvc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic mode_10bt,
   input wire logic aneg_active,
   input wire logic duplex_request,
   output logic full_duplex,
   input wire logic rx_activity,
   output logic crs,
   output logic col,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   input wire logic phy_rx_dv,
   input wire logic [3:0] phy_rxd,
   output logic rx_dv,
   output logic [3:0] rxd,
   input wire logic [1:0] tx_line_drive,
   output logic [1:0] tx_line_pair,
   output logic tx_line_pair_oe,
   input wire logic tx_clk_gen,
   output logic tx_clk_out,
   output logic tx_clk_oe,
   input wire logic rx_line_in,
   output logic rx_line_data,
   input wire logic nlp_pulse,
   input wire logic nlp_inverted,
   input wire logic flp_done,
   input wire logic flp_inverted,
   input wire logic [7:0] irq_status,
   input wire logic [7:0] irq_enable,
   output logic irq_out
);
   import pvc_pkg::*;

   logic repeater_select;
   logic irq_level_select;
   logic tx_hiz_select;
   logic heartbeat_inhibit;
   logic ten_meg_loopback;
   logic polarity_auto_disable;
   logic rx_polarity_flip;
   logic [1:0] rsv_rw;
   logic reg_write;
   logic reg_read;
   logic [15:0] read_value;
   logic pol_enable;
   logic pol_reversed;
   logic tx_en_d;
   logic tx_done;
   logic sqe_allow;
   logic irq_pending;
   pvc_sqe_e sqe_state;
   logic [4:0] sqe_count;

   assign reg_write = reg_wr && (reg_addr == VCR_ADDR);
   assign reg_read = reg_rd && (reg_addr == VCR_ADDR);

   // ****************************************
   // control register bits
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         repeater_select <= RST_REPEATER;
         irq_level_select <= RST_IRQ_LEVEL;
         tx_hiz_select <= RST_TX_HIZ;
         heartbeat_inhibit <= RST_HB_INHIBIT;
         ten_meg_loopback <= RST_LOOPBACK;
         polarity_auto_disable <= RST_POLARITY_AUTO_DISABLE_DIS;
         rsv_rw <= RST_RSV_RW;
      end else if (reg_write) begin
         repeater_select <= reg_wdata[BIT_REPEATER];
         irq_level_select <= reg_wdata[BIT_IRQ_LEVEL];
         tx_hiz_select <= reg_wdata[BIT_TX_HIZ];
         heartbeat_inhibit <= reg_wdata[BIT_HB_INHIBIT];
         ten_meg_loopback <= reg_wdata[BIT_LOOPBACK];
         polarity_auto_disable <= reg_wdata[BIT_POLARITY_AUTO_DISABLE_DIS];
         rsv_rw <= reg_wdata[RSV_RW_MSB:RSV_RW_LSB];
      end
   end

   // ****************************************
   // polarity flip bit
   // ****************************************
   // detection window and disable
   assign pol_enable = (aneg_active || mode_10bt) && !polarity_auto_disable;

   pvc_polarity_detect u_pol (
      .clk (clk),
      .srst (srst),
      .enable (pol_enable),
      .nlp_pulse (nlp_pulse),
      .nlp_inverted (nlp_inverted),
      .flp_done (flp_done),
      .flp_inverted (flp_inverted),
      .reversed (pol_reversed)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_polarity_flip <= RST_RX_FLIP;
      end else if (pol_reversed && !polarity_auto_disable) begin
         rx_polarity_flip <= 1'b1;
      end else if (reg_write && polarity_auto_disable) begin
         rx_polarity_flip <= reg_wdata[BIT_RX_FLIP];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_line_data <= 1'b0;
      end else begin
         rx_line_data <= rx_line_in ^ rx_polarity_flip;
      end
   end

   // ****************************************
   // read path
   // ****************************************
   // fixed reserved bits
   always_comb begin
      read_value = FIXED_ONES;
      read_value[BIT_REPEATER] = repeater_select;
      read_value[BIT_IRQ_LEVEL] = irq_level_select;
      read_value[BIT_TX_HIZ] = tx_hiz_select;
      read_value[BIT_HB_INHIBIT] = heartbeat_inhibit;
      read_value[BIT_LOOPBACK] = ten_meg_loopback;
      read_value[BIT_POLARITY_AUTO_DISABLE_DIS] = polarity_auto_disable;
      read_value[BIT_RX_FLIP] = rx_polarity_flip;
      read_value[RSV_RW_MSB:RSV_RW_LSB] = rsv_rw;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= RST_RDATA;
      end else if (reg_rd) begin
         reg_rdata <= reg_read ? read_value : RST_RDATA;
      end
   end

   // ****************************************
   // duplex and carrier sense
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         full_duplex <= 1'b0;
         crs <= 1'b0;
      end else begin
         full_duplex <= duplex_request && !repeater_select;
         crs <= rx_activity ||
                (tx_en && !repeater_select && !full_duplex);
      end
   end

   // ****************************************
   // sqe test pulse
   // ****************************************
   assign tx_done = tx_en_d && !tx_en;
   assign sqe_allow = mode_10bt && !heartbeat_inhibit && !repeater_select;

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_en_d <= 1'b0;
      end else begin
         tx_en_d <= tx_en;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sqe_state <= PVC_SQE_IDLE;
         sqe_count <= 5'h00;
      end else begin
         unique case (sqe_state)
            PVC_SQE_IDLE: begin
               sqe_count <= 5'h00;
               if (tx_done && sqe_allow) begin
                  sqe_state <= PVC_SQE_PULSE;
               end
            end
            PVC_SQE_PULSE: begin
               sqe_count <= sqe_count + 5'h01;
               if (sqe_count == SQE_LAST) begin
                  sqe_state <= PVC_SQE_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         col <= 1'b0;
      end else begin
         col <= (sqe_state == PVC_SQE_PULSE) ||
                (tx_en && rx_activity && !full_duplex);
      end
   end

   // ****************************************
   // receive data path and loopback
   // ****************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_dv <= 1'b0;
         rxd <= 4'h0;
      end else if (ten_meg_loopback && mode_10bt) begin
         rx_dv <= tx_en;
         rxd <= txd;
      end else begin
         rx_dv <= phy_rx_dv;
         rxd <= phy_rxd;
      end
   end

   // ****************************************
   // transmitter high impedance
   // ****************************************
   // release line pair and tx clock
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_line_pair <= 2'h0;
         tx_line_pair_oe <= 1'b0;
         tx_clk_out <= 1'b0;
         tx_clk_oe <= 1'b0;
      end else begin
         tx_line_pair <= tx_line_drive;
         tx_line_pair_oe <= !tx_hiz_select;
         tx_clk_out <= tx_clk_gen;
         tx_clk_oe <= !tx_hiz_select;
      end
   end

   // ****************************************
   // interrupt pin
   // ****************************************
   assign irq_pending = |(irq_status & irq_enable);

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_out <= 1'b1;
      end else begin
         irq_out <= irq_pending ? irq_level_select : !irq_level_select;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_no_fdx;
      repeater_select |=> !full_duplex;
   endproperty
   a_no_fdx: assert property (p_no_fdx)
      else $error("full duplex while repeater selected");

   property p_crs_rx_only;
      repeater_select && !rx_activity |=> !crs;
   endproperty
   a_crs_rx_only: assert property (p_crs_rx_only)
      else $error("crs without receive activity in repeater mode");

   property p_irq_level;
      irq_pending |=> irq_out == $past(irq_level_select);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq_out at wrong asserted level");

   property p_irq_idle;
      !irq_pending |=> irq_out != $past(irq_level_select);
   endproperty
   a_irq_idle: assert property (p_irq_idle)
      else $error("irq_out asserted with nothing enabled");

   property p_hiz;
      tx_hiz_select |=> !tx_line_pair_oe && !tx_clk_oe;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("transmitter driven in high-impedance mode");

   property p_sqe_pulse;
      sqe_state == PVC_SQE_IDLE && tx_done && sqe_allow
         |=> ##1 col [*8];
   endproperty
   a_sqe_pulse: assert property (p_sqe_pulse)
      else $error("sqe col pulse missing after transmission");

   property p_sqe_off;
      tx_done && mode_10bt && heartbeat_inhibit
         |=> sqe_state == PVC_SQE_IDLE;
   endproperty
   a_sqe_off: assert property (p_sqe_off)
      else $error("sqe pulse started while inhibited");

   property p_loop;
      ten_meg_loopback && mode_10bt |=> rxd == $past(txd) &&
         rx_dv == $past(tx_en);
   endproperty
   a_loop: assert property (p_loop)
      else $error("loopback nibble not returned");

   property p_auto_set;
      pol_reversed && !polarity_auto_disable |=> rx_polarity_flip;
   endproperty
   a_auto_set: assert property (p_auto_set)
      else $error("flip bit not set on detected reversal");

   property p_no_detect;
      polarity_auto_disable |=> !pol_reversed;
   endproperty
   a_no_detect: assert property (p_no_detect)
      else $error("polarity detected while auto disabled");

   property p_manual_flip;
      reg_write && polarity_auto_disable |=>
         rx_polarity_flip == $past(reg_wdata[BIT_RX_FLIP]) ##1
         rx_line_data == ($past(rx_line_in) ^ $past(rx_polarity_flip));
   endproperty
   a_manual_flip: assert property (p_manual_flip)
      else $error("manual flip not applied");

   property p_fixed_bits;
      reg_read |=> (reg_rdata & FIXED_MASK) == FIXED_ONES;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("reserved read-only bits wrong");

   c_sqe: cover property (tx_done && sqe_allow);
   c_loop: cover property (ten_meg_loopback && mode_10bt && tx_en);
   c_flip: cover property (pol_reversed && !polarity_auto_disable);
   c_irq_high: cover property (irq_pending && irq_level_select);
endmodule
